//--- mcw_cfg.svh
// Purpose: constants for the mode command record writer
// Assumes: 16-bit shared RAM words, 16-bit RAM addresses
// Notes: record words are written by this block after the message ends, the data word only when mode code bit 4 is set
`ifndef MCW_CFG_SVH
`define MCW_CFG_SVH
`define MCW_BIT_INVALID 14
`define MCW_BIT_GAPBC 13
`define MCW_BIT_WCNT 12
`define MCW_BIT_SYNC 11
`define MCW_BIT_MSGFLT 10
`define MCW_BIT_BUSY 9
`define MCW_BIT_ILL 8
`define MCW_BIT_BUS 5
`define MCW_DATA_CODE_BIT 4
`define MCW_OFS_TAG 16'h0001
`define MCW_OFS_DATA 16'h0002
`define MCW_MC_UNDEF_A 5'h10
`define MCW_MC_UNDEF_B 5'h12
`define MCW_MC_UNDEF_C 5'h13
`endif

//--- mcw_host_ram.sv
// Purpose: host side shared RAM that collects record words from the writer
// Assumes: pointers used by the bench stay below 16'h00FC
// Notes: only the low 8 address bits are kept, so higher addresses alias
`timescale 1ns/1ps
module mcw_host_ram (
   input wire logic clk_in,
   input wire logic we_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in
);
   // ***************************************************
   // storage, preset to a marker so untouched words show
   // ***************************************************
   logic [15:0] mem [0:255];
   int writes = 0;
   initial begin
      foreach (mem[i]) mem[i] = 16'hA5A5;
   end
   always @(posedge clk_in) begin
      if (we_in === 1'b1) begin
         mem[addr_in[7:0]] <= wdata_in;
         writes <= writes + 1;
      end
   end
endmodule // mcw_host_ram

//--- mcw_pkg.sv
// Purpose: types for the mode command record writer
// Assumes: nothing beyond the constants header
// Notes: the state of the writer is one packed struct
package mcw_pkg;
   typedef enum logic [1:0] {
      MCW_IDLE = 2'b00,
      MCW_INFO = 2'b01,
      MCW_TAG = 2'b10,
      MCW_DATA = 2'b11
   } mcw_state_t;

   // results of a finished receive mode command
   typedef struct packed {
      logic [15:0] pointer;
      logic [15:0] time_tag;
      logic [15:0] data_word;
      logic [4:0] mode_code;
      logic bus_b;
      logic broadcast;
      logic data_bad;
      logic gap_fault;
      logic count_fault;
      logic sync_fault;
      logic busy;
      logic illegal;
   } mcw_msg_t;

   typedef struct packed {
      mcw_state_t state;
      logic [15:0] info;
      logic [15:0] tag;
      logic [15:0] data;
      logic [15:0] base;
      logic has_data;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mcw_regs_t;
endpackage

//--- mcw_writer.sv
// Purpose: writes receive mode command records into shared RAM
// Assumes: message results are valid in the cycle MSG_DONE_IN pulses
// Notes: one RAM word per cycle; a new MSG_DONE_IN is ignored while busy
`timescale 1ns/1ps
`include "mcw_cfg.svh"
module mcw_writer (
   // clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   // message results
   input wire logic MSG_DONE_IN,
   input wire mcw_pkg::mcw_msg_t MSG_IN,
   // configuration
   input wire logic GAP_OR_BROADCAST_SELECT_IN,
   input wire logic UNDEFINED_MODE_INVALID_SELECT_IN,
   input wire logic GLOBAL_BUSY_IN,
   input wire logic PER_COMMAND_BUSY_FORCE_IN,
   // response decision
   output logic RESPOND_IN_FORM_OUT,
   // shared RAM write port and busy flag
   output logic RAM_WE_OUT,
   output logic [15:0] RAM_ADDR_OUT,
   output logic [15:0] RAM_WDATA_OUT,
   output logic BUSY_OUT
);
   mcw_pkg::mcw_regs_t r;
   mcw_pkg::mcw_regs_t next_r;
   logic [15:0] info_word;
   logic [4:0] mc;

   // ************************************
   // decode helpers
   // ************************************
   function automatic logic is_undefined_rx(input logic [4:0] code);
      is_undefined_rx = !code[`MCW_DATA_CODE_BIT] || code == `MCW_MC_UNDEF_A
         || code == `MCW_MC_UNDEF_B || code == `MCW_MC_UNDEF_C;
   endfunction

   assign mc = MSG_IN.mode_code;

   // undefined codes answer only when nothing marks them invalid
   always_comb begin
      if (is_undefined_rx(mc)) begin
         RESPOND_IN_FORM_OUT = !MSG_IN.illegal && !UNDEFINED_MODE_INVALID_SELECT_IN;
      end else begin
         RESPOND_IN_FORM_OUT = !MSG_IN.illegal;
      end
   end

   // ************************************
   // information word
   // ************************************
   always_comb begin
      info_word = 16'h0000;
      info_word[`MCW_BIT_INVALID] = MSG_IN.data_bad;
      info_word[`MCW_BIT_GAPBC] = GAP_OR_BROADCAST_SELECT_IN ? MSG_IN.broadcast
         : MSG_IN.gap_fault;
      info_word[`MCW_BIT_WCNT] = MSG_IN.count_fault;
      info_word[`MCW_BIT_SYNC] = MSG_IN.sync_fault;
      info_word[`MCW_BIT_MSGFLT] = MSG_IN.data_bad || MSG_IN.gap_fault
         || MSG_IN.count_fault || MSG_IN.sync_fault;
      info_word[`MCW_BIT_BUSY] = MSG_IN.busy || GLOBAL_BUSY_IN || PER_COMMAND_BUSY_FORCE_IN;
      info_word[`MCW_BIT_ILL] = MSG_IN.illegal;
      info_word[`MCW_BIT_BUS] = MSG_IN.bus_b;
      info_word[4:0] = mc;
   end

   // ************************************
   // record sequencer
   // ************************************
   always_comb begin
      next_r = r;
      next_r.we = 1'b0;
      unique case (r.state)
         mcw_pkg::MCW_IDLE: begin
            if (MSG_DONE_IN) begin
               // capture only after completion so no record is started from an unfinished message
               next_r.info = info_word;
               next_r.tag = MSG_IN.time_tag;
               next_r.data = MSG_IN.data_word;
               next_r.base = MSG_IN.pointer;
               next_r.has_data = mc[`MCW_DATA_CODE_BIT];
               next_r.state = mcw_pkg::MCW_INFO;
            end
         end
         mcw_pkg::MCW_INFO: begin
            next_r.we = 1'b1;
            next_r.addr = r.base;
            next_r.wdata = r.info;
            next_r.state = mcw_pkg::MCW_TAG;
         end
         mcw_pkg::MCW_TAG: begin
            next_r.we = 1'b1;
            next_r.addr = r.base + `MCW_OFS_TAG;
            next_r.wdata = r.tag;
            next_r.state = r.has_data ? mcw_pkg::MCW_DATA : mcw_pkg::MCW_IDLE;
         end
         mcw_pkg::MCW_DATA: begin
            next_r.we = 1'b1;
            next_r.addr = r.base + `MCW_OFS_DATA;
            next_r.wdata = r.data;
            next_r.state = mcw_pkg::MCW_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign RAM_WE_OUT = r.we;
   assign RAM_ADDR_OUT = r.addr;
   assign RAM_WDATA_OUT = r.wdata;
   assign BUSY_OUT = r.state != mcw_pkg::MCW_IDLE;

   // ************************************
   // checks
   // ************************************
   AST_INFO_AT_BASE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##1 (RAM_WE_OUT && RAM_ADDR_OUT == $past(MSG_IN.pointer, 2)))
      else $error("info word not at pointer");
   AST_TAG_NEXT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##2 (RAM_WE_OUT
         && RAM_ADDR_OUT == $past(MSG_IN.pointer, 3) + 16'h0001))
      else $error("time tag not at pointer plus one");
   AST_DATA_PLUS2: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT && mc[4]) |=> ##3 (RAM_WE_OUT
         && RAM_ADDR_OUT == $past(MSG_IN.pointer, 4) + 16'h0002))
      else $error("data word not at pointer plus two");
   AST_NO_DATA_LOW: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT && !mc[4]) |=> ##3 !RAM_WE_OUT)
      else $error("data slot written for low mode code");
   AST_NO_WRITE_IDLE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (!BUSY_OUT && !MSG_DONE_IN) |=> !RAM_WE_OUT)
      else $error("write without completed message");
   AST_DATA_STORED: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT && mc[4]) |=> ##3 (RAM_WDATA_OUT == $past(MSG_IN.data_word, 4)))
      else $error("mode data word not stored");
   AST_MSG_FAULT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##1 (RAM_WDATA_OUT[10] == ($past(MSG_IN.data_bad, 2)
         || $past(MSG_IN.gap_fault, 2) || $past(MSG_IN.count_fault, 2)
         || $past(MSG_IN.sync_fault, 2))))
      else $error("message error flag mismatch");
   AST_UNUSED_ZERO: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##1 (RAM_WDATA_OUT[15] == 1'b0 && RAM_WDATA_OUT[7:6] == 2'b00))
      else $error("unused info bits not zero");
   AST_UNDEF_INVALID: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (UNDEFINED_MODE_INVALID_SELECT_IN && !mc[4]) |-> !RESPOND_IN_FORM_OUT)
      else $error("undefined code answered while invalid");
   AST_UNDEF_DATA_INVALID: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (UNDEFINED_MODE_INVALID_SELECT_IN && (mc == 5'h10 || mc == 5'h12 || mc == 5'h13))
         |-> !RESPOND_IN_FORM_OUT)
      else $error("undefined data code answered while invalid");
   AST_ILLEGAL_BIT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##1 (RAM_WDATA_OUT[8] == $past(MSG_IN.illegal, 2)))
      else $error("illegal command bit wrong");
   AST_BUS_BIT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##1 (RAM_WDATA_OUT[5] == $past(MSG_IN.bus_b, 2)))
      else $error("bus select bit wrong");
   AST_MODE_FIELD: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
      (MSG_DONE_IN && !BUSY_OUT) |=> ##1 (RAM_WDATA_OUT[4:0] == $past(mc, 2)))
      else $error("mode code field wrong");
endmodule // mcw_writer

//--- tb_mode_command_record_writer.sv
// Purpose: self-checking bench for the mode command record writer
// Assumes: record walk of five cycles per message
// Notes: illegal entries stay zero except where a test wants them
`timescale 1ns/1ps
module tb_mode_command_record_writer;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic done = 1'b0;
   mcw_pkg::mcw_msg_t msg = '0;
   logic sel = 1'b0;
   logic inv = 1'b0;
   logic gbusy = 1'b0;
   logic pbusy = 1'b0;
   logic rif, we, busy;
   logic [15:0] addr, wdata;
   int errors = 0;
   int check_count = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   mcw_writer dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .MSG_DONE_IN(done), .MSG_IN(msg),
      .GAP_OR_BROADCAST_SELECT_IN(sel), .UNDEFINED_MODE_INVALID_SELECT_IN(inv),
      .GLOBAL_BUSY_IN(gbusy), .PER_COMMAND_BUSY_FORCE_IN(pbusy), .RESPOND_IN_FORM_OUT(rif),
      .RAM_WE_OUT(we), .RAM_ADDR_OUT(addr), .RAM_WDATA_OUT(wdata), .BUSY_OUT(busy));
   mcw_host_ram ram_u (.clk_in(clk), .we_in(we), .addr_in(addr), .wdata_in(wdata));
   // ***************************************************
   // helpers
   // ***************************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic mcw_pkg::mcw_msg_t mk(input logic [4:0] c, input logic [15:0] p,
      input logic [7:0] f);
      mcw_pkg::mcw_msg_t m;
      m.pointer = p;
      m.time_tag = 16'h7100 + p;
      m.data_word = 16'h3C00 + p;
      m.mode_code = c;
      {m.illegal, m.busy, m.sync_fault, m.count_fault, m.gap_fault, m.data_bad,
         m.broadcast, m.bus_b} = f;
      return m;
   endfunction
   function automatic logic [15:0] info_of(input mcw_pkg::mcw_msg_t m);
      logic [15:0] w;
      w = {1'b0, m.data_bad, sel ? m.broadcast : m.gap_fault, m.count_fault, m.sync_fault,
         m.data_bad | m.gap_fault | m.count_fault | m.sync_fault, m.busy | gbusy | pbusy,
         m.illegal, 2'b00, m.bus_b, m.mode_code};
      return w;
   endfunction
   task automatic run_msg(input mcw_pkg::mcw_msg_t m);
      logic undef;
      int base;
      undef = (m.mode_code < 5'h10) || (m.mode_code inside {5'h10, 5'h12, 5'h13});
      base = ram_u.writes;
      msg = m;
      done = 1'b1;
      #1;
      check("respond", {15'h0000, rif}, {15'h0000, ~m.illegal & ~(undef & inv)});
      @(posedge clk);
      #1;
      done = 1'b0;
      check("early", 16'(ram_u.writes - base), 16'h0000);
      check("busy early", {15'h0000, busy}, 16'h0001);
      repeat (6) @(posedge clk);
      #1;
      check("busy", {15'h0000, busy}, 16'h0000);
      check("count", 16'(ram_u.writes - base), m.mode_code[4] ? 16'h0003 : 16'h0002);
      check("info", ram_u.mem[m.pointer[7:0]], info_of(m));
      check("tag", ram_u.mem[m.pointer[7:0] + 8'h01], m.time_tag);
      check("data", ram_u.mem[m.pointer[7:0] + 8'h02],
         m.mode_code[4] ? m.data_word : 16'hA5A5);
   endtask
   // ***************************************************
   // tests
   // ***************************************************
   task automatic test_all_codes();
      for (int i = 0; i < 32; i++) run_msg(mk(5'(i), 16'(i * 4), {2'b00, 6'(i * 5)}));
      $display("test all codes done");
   endtask
   task automatic test_broadcast();
      sel = 1'b1;
      run_msg(mk(5'h12, 16'h0080, 8'h02));
      run_msg(mk(5'h03, 16'h0084, 8'h04));
      sel = 1'b0;
      $display("test broadcast done");
   endtask
   task automatic test_busy_illegal();
      gbusy = 1'b1;
      run_msg(mk(5'h11, 16'h0090, 8'h00));
      gbusy = 1'b0;
      pbusy = 1'b1;
      run_msg(mk(5'h01, 16'h0094, 8'h01));
      pbusy = 1'b0;
      inv = 1'b1;
      run_msg(mk(5'h05, 16'h0098, 8'h00));
      run_msg(mk(5'h11, 16'h009C, 8'h00));
      run_msg(mk(5'h13, 16'h00A0, 8'h80));
      inv = 1'b0;
      run_msg(mk(5'h10, 16'h00A4, 8'h80));
      $display("test busy illegal done");
   endtask
   task automatic test_refused();
      int base;
      base = ram_u.writes;
      msg = mk(5'h14, 16'h00B0, 8'h00);
      done = 1'b1;
      @(posedge clk);
      #1;
      msg = mk(5'h02, 16'h00C0, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      done = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check("refused count", 16'(ram_u.writes - base), 16'h0003);
      check("refused slot", ram_u.mem[8'hC0], 16'hA5A5);
      check("first data", ram_u.mem[8'hB2], 16'h3CB0);
      $display("test refused done");
   endtask
   task automatic test_reset_mid();
      int base;
      base = ram_u.writes;
      msg = mk(5'h15, 16'h00C8, 8'h00);
      done = 1'b1;
      @(posedge clk);
      #1;
      done = 1'b0;
      @(posedge clk);
      #1;
      rst = 1'b1;
      @(posedge clk);
      #1;
      check("reset we", {15'h0000, we}, 16'h0000);
      check("reset busy", {15'h0000, busy}, 16'h0000);
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check("reset count", 16'(ram_u.writes - base), 16'h0001);
      check("reset slot", ram_u.mem[8'hCA], 16'hA5A5);
      run_msg(mk(5'h16, 16'h00D0, 8'h21));
      $display("test reset mid done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      check("idle we", {15'h0000, we}, 16'h0000);
      test_all_codes();
      test_broadcast();
      test_busy_illegal();
      test_refused();
      test_reset_mid();
      complete_run();
   end
   initial begin
      #20000;
      errors++;
      complete_run();
   end
endmodule // tb_mode_command_record_writer
